// ---- shared/bmc_pkg.sv ----
// Contract
// - Fuse loads active and sleep modes at reset
// - Software writes never change active mode
// - Software may write the sleep mode field
// - Entering deep sleep uses sleep mode
// - Waking from deep sleep restores active mode
// - Sleep field writable only after unlock key
// - Unguarded protected writes change nothing at all
// - Bit four picks 1 kHz or 125 Hz
// - Active mode codes: off, on, sampled, hold
// - Sleep mode codes: off, on, sampled, reserved
// - Read-only threshold field loaded from fuse
// - Warning level code sets margin, reset zero
// - Trigger codes: falling, rising, either, reserved
// - Interrupt enable bit gates warning request
// - Flag set on trigger, even while interrupt disabled
package bmc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register indices, byte address is four times the index
  localparam logic [5:0] IDX_MODE_CTRL = 6'h00;
  localparam logic [5:0] IDX_LEVEL_CTRL = 6'h01;
  localparam logic [5:0] IDX_WARN_LEVEL = 6'h08;
  localparam logic [5:0] IDX_WARN_IRQ_CTRL = 6'h09;
  localparam logic [5:0] IDX_WARN_FLAGS = 6'h0A;
  localparam logic [5:0] IDX_WARN_STATUS = 6'h0B;
  localparam logic [5:0] IDX_WARN_CLEAR = 6'h0C;

  // Field positions
  localparam int SAMPLE_RATE_BIT = 4;
  localparam int ACTIVE_LSB = 2;
  localparam int SLEEP_LSB = 0;
  localparam int TRIG_LSB = 1;
  localparam int IRQ_EN_BIT = 0;
  localparam int FLAG_BIT = 0;

  // Reset values of software fields
  localparam logic [1:0] WARN_LEVEL_RESET = 2'h0;
  localparam logic [1:0] TRIG_RESET = 2'h0;
  localparam logic IRQ_EN_RESET = 1'h0;

  // Bus answers
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Unlock window length in retired instructions
  localparam logic [2:0] UNLOCK_INSTR = 3'h4;

  // Low-power clock and sample timing
  localparam int LP_CLK_HZ = 32768;
  localparam int SAMPLE_FAST_HZ = 1000;
  localparam int SAMPLE_SLOW_HZ = 125;
  localparam logic [8:0] PERIOD_FAST =
    9'(LP_CLK_HZ / SAMPLE_FAST_HZ);
  localparam logic [8:0] PERIOD_SLOW =
    9'(LP_CLK_HZ / SAMPLE_SLOW_HZ);
  localparam logic [8:0] WINDOW_TICKS = 9'h002;

  // Synchronised pin count
  localparam int PIN_COUNT = 4;

  ////////////////////////////////////////////////////////////////////////////
  // Detector operating modes
  typedef enum logic [1:0] {
    MODE_DISABLED = 2'h0,
    MODE_ENABLED = 2'h1,
    MODE_SAMPLED = 2'h2,
    MODE_ENABLED_HOLD = 2'h3
  } bmc_mode_t;

  // Warning trigger selections
  localparam logic [1:0] TRIG_FALL = 2'h0;
  localparam logic [1:0] TRIG_RISE = 2'h1;
  localparam logic [1:0] TRIG_BOTH = 2'h2;

  // Power phase, one-hot
  typedef enum logic [2:0] {
    PH_ACTIVE = 3'h1,
    PH_SLEEP = 3'h2,
    PH_WAKE_WAIT = 3'h4
  } bmc_phase_t;

  ////////////////////////////////////////////////////////////////////////////
  // Configuration fuse content
  typedef struct packed {
    logic sample_rate;
    logic [1:0] active_mode;
    logic [1:0] sleep_mode;
    logic [2:0] threshold;
  } bmc_fuse_t;

  // Analog and slow-clock pins
  typedef struct packed {
    logic lp_clk;
    logic below_threshold;
    logic below_warning;
    logic detector_ready;
  } bmc_pins_t;

  // Synchroniser state
  typedef struct packed {
    logic [PIN_COUNT-1:0] s1;
    logic [PIN_COUNT-1:0] s2;
    logic [PIN_COUNT-1:0] s3;
    logic [PIN_COUNT-1:0] q;
  } bmc_sync_t;

  // Main block state
  typedef struct packed {
    bmc_phase_t phase;
    logic sample_rate;
    logic [1:0] active_mode;
    logic [1:0] sleep_mode;
    logic [2:0] threshold;
    logic [1:0] warn_level;
    logic [1:0] trig_sel;
    logic irq_en;
    logic irq_flag;
    logic warn_state;
    logic below_held;
    logic [2:0] unlock_cnt;
    logic lp_prev;
    logic [8:0] tick_cnt;
    logic comp_en;
    logic [1:0] det_mode;
    logic wake_hold;
    logic aw_held;
    logic [5:0] aw_idx;
    logic w_held;
    logic [7:0] wdata;
    logic wlane0;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } bmc_state_t;

endpackage : bmc_pkg

// ---- logic/bmc_pin_sync.sv ----
`timescale 1ns/100ps
module bmc_pin_sync (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [bmc_pkg::PIN_COUNT-1:0] pin_in,
  output logic [bmc_pkg::PIN_COUNT-1:0] pin_q
);

  ////////////////////////////////////////////////////////////////////////////
  bmc_pkg::bmc_sync_t s; // Current state
  bmc_pkg::bmc_sync_t next_s; // Next state

  // Three-stage chain; a change counts once stages two and three agree
  always_comb begin
    next_s = s;
    next_s.s1 = pin_in;
    next_s.s2 = s.s1;
    next_s.s3 = s.s2;
    for (int i = 0; i < bmc_pkg::PIN_COUNT; i++) begin
      if (s.s2[i] == s.s3[i]) begin
        next_s.q[i] = s.s3[i];
      end
    end
    if (!aresetn) begin
      next_s = '0;
    end
  end

  // State register
  always_ff @(posedge aclk) begin
    s <= next_s;
  end

  assign pin_q = s.q;

endmodule : bmc_pin_sync

// ---- logic/bmc_control.sv ----
`timescale 1ns/100ps
module bmc_control (
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Configuration fuse, stable while reset is held
  input wire bmc_pkg::bmc_fuse_t detector_config_fuse,
  // Sleep controller
  input wire logic deep_sleep,
  output logic wake_hold,
  // Change guard from the processor
  input wire logic io_register_unlock_key,
  input wire logic instr_retired,
  // Analog side
  input wire bmc_pkg::bmc_pins_t analog_pins,
  output logic comparator_enable,
  output logic [1:0] brownout_detector_mode,
  output logic [2:0] threshold_select,
  output logic [1:0] warning_level_select,
  output logic reset_request,
  output logic irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Signals
  bmc_pkg::bmc_state_t s; // Current state
  bmc_pkg::bmc_state_t next_s; // Next state
  bmc_pkg::bmc_pins_t pins_q; // Synchronised pins
  logic aw_take; // Write address taken
  logic w_take; // Write data taken
  logic ar_take; // Read address taken
  logic [1:0] eff_mode; // Mode the detector runs in
  logic det_on; // Detector not disabled
  logic lp_tick; // Rising edge of the slow clock
  logic [8:0] period; // Sample period in slow ticks
  logic sample_now; // New comparator reading is valid
  logic warn_new; // Warning comparator value at sample
  logic cross_fall; // Supply fell below warning level
  logic cross_rise; // Supply rose above warning level
  logic trigger; // Selected trigger occurred
  logic do_write; // Write executes this cycle
  logic unlocked; // Guard window open
  logic [7:0] rd_byte; // Read data before padding
  logic rd_hit; // Read address mapped
  logic wr_hit; // Write address mapped

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchroniser
  bmc_pin_sync u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .pin_in(analog_pins),
    .pin_q(pins_q)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Handshake outputs
  assign s_axi_awready = !s.aw_held && !s.bvalid;
  assign s_axi_wready = !s.w_held && !s.bvalid;
  assign s_axi_arready = !s.rvalid;
  assign aw_take = s_axi_awvalid && s_axi_awready;
  assign w_take = s_axi_wvalid && s_axi_wready;
  assign ar_take = s_axi_arvalid && s_axi_arready;
  assign do_write = s.aw_held && s.w_held && !s.bvalid;
  assign unlocked = (s.unlock_cnt != 3'h0);

  ////////////////////////////////////////////////////////////////////////////
  // Effective mode per power phase
  always_comb begin
    eff_mode = s.active_mode;
    if (s.phase == bmc_pkg::PH_SLEEP) begin
      eff_mode = s.sleep_mode;
      if (s.sleep_mode == bmc_pkg::MODE_ENABLED_HOLD) begin
        eff_mode = bmc_pkg::MODE_DISABLED;
      end
    end
  end

  assign det_on = (eff_mode != bmc_pkg::MODE_DISABLED);

  ////////////////////////////////////////////////////////////////////////////
  // Sample timing from the slow clock
  assign lp_tick = pins_q.lp_clk && !s.lp_prev;
  assign period = s.sample_rate ? bmc_pkg::PERIOD_SLOW
                                : bmc_pkg::PERIOD_FAST;

  // Reading is fresh every cycle when enabled, at window end when sampled
  always_comb begin
    sample_now = 1'b0;
    if (eff_mode == bmc_pkg::MODE_SAMPLED) begin
      sample_now = lp_tick &&
        (s.tick_cnt == bmc_pkg::WINDOW_TICKS - 9'h001);
    end else if (det_on) begin
      sample_now = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Warning crossings
  assign warn_new = pins_q.below_warning;
  assign cross_fall = warn_new && !s.warn_state;
  assign cross_rise = !warn_new && s.warn_state;

  // Trigger decode
  always_comb begin
    unique case (s.trig_sel)
      bmc_pkg::TRIG_FALL: begin
        trigger = cross_fall;
      end
      bmc_pkg::TRIG_RISE: begin
        trigger = cross_rise;
      end
      bmc_pkg::TRIG_BOTH: begin
        trigger = cross_fall || cross_rise;
      end
      default: begin
        trigger = 1'b0; // Reserved code
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register read mux
  always_comb begin
    rd_byte = 8'h00;
    rd_hit = 1'b1;
    unique case (s_axi_araddr[7:2])
      bmc_pkg::IDX_MODE_CTRL: begin
        rd_byte[bmc_pkg::SAMPLE_RATE_BIT] = s.sample_rate;
        rd_byte[bmc_pkg::ACTIVE_LSB +: 2] = s.active_mode;
        rd_byte[bmc_pkg::SLEEP_LSB +: 2] = s.sleep_mode;
      end
      bmc_pkg::IDX_LEVEL_CTRL: begin
        rd_byte[2:0] = s.threshold;
      end
      bmc_pkg::IDX_WARN_LEVEL: begin
        rd_byte[1:0] = s.warn_level;
      end
      bmc_pkg::IDX_WARN_IRQ_CTRL: begin
        rd_byte[bmc_pkg::TRIG_LSB +: 2] = s.trig_sel;
        rd_byte[bmc_pkg::IRQ_EN_BIT] = s.irq_en;
      end
      bmc_pkg::IDX_WARN_FLAGS: begin
        rd_byte[bmc_pkg::FLAG_BIT] = s.irq_flag;
      end
      bmc_pkg::IDX_WARN_STATUS: begin
        rd_byte[0] = s.warn_state;
      end
      bmc_pkg::IDX_WARN_CLEAR: begin
        rd_byte = 8'h00; // Write-only
      end
      default: begin
        rd_hit = 1'b0; // Unmapped
      end
    endcase
  end

  // Write decode
  always_comb begin
    unique case (s.aw_idx)
      bmc_pkg::IDX_MODE_CTRL, bmc_pkg::IDX_LEVEL_CTRL,
      bmc_pkg::IDX_WARN_LEVEL, bmc_pkg::IDX_WARN_IRQ_CTRL,
      bmc_pkg::IDX_WARN_FLAGS, bmc_pkg::IDX_WARN_STATUS,
      bmc_pkg::IDX_WARN_CLEAR: begin
        wr_hit = 1'b1;
      end
      default: begin
        wr_hit = 1'b0;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic
  always_comb begin
    next_s = s;

    // Write channel capture
    if (aw_take) begin
      next_s.aw_held = 1'b1;
      next_s.aw_idx = s_axi_awaddr[7:2];
    end
    if (w_take) begin
      next_s.w_held = 1'b1;
      next_s.wdata = s_axi_wdata[7:0];
      next_s.wlane0 = s_axi_wstrb[0];
    end
    if (s.bvalid && s_axi_bready) begin
      next_s.bvalid = 1'b0;
    end

    // Read channel
    if (s.rvalid && s_axi_rready) begin
      next_s.rvalid = 1'b0;
    end
    if (ar_take) begin
      next_s.rvalid = 1'b1;
      next_s.rdata = {24'h000000, rd_byte};
      next_s.rresp = rd_hit ? bmc_pkg::RESP_OKAY : bmc_pkg::RESP_SLVERR;
    end

    // Guard window opens on the key and closes after four instructions
    if (io_register_unlock_key) begin
      next_s.unlock_cnt = bmc_pkg::UNLOCK_INSTR;
    end else if (instr_retired && unlocked) begin
      next_s.unlock_cnt = s.unlock_cnt - 3'h1;
    end

    // Clear requests of the warning flag
    if (do_write && s.wlane0 && s.wdata[bmc_pkg::FLAG_BIT]) begin
      if (s.aw_idx == bmc_pkg::IDX_WARN_FLAGS ||
          s.aw_idx == bmc_pkg::IDX_WARN_CLEAR) begin
        next_s.irq_flag = 1'b0;
      end
    end

    // Register writes
    if (do_write) begin
      next_s.aw_held = 1'b0;
      next_s.w_held = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp = wr_hit ? bmc_pkg::RESP_OKAY : bmc_pkg::RESP_SLVERR;
      if (s.wlane0) begin
        unique case (s.aw_idx)
          bmc_pkg::IDX_MODE_CTRL: begin
            // Active field never written; others need the guard
            if (unlocked) begin
              next_s.sleep_mode =
                s.wdata[bmc_pkg::SLEEP_LSB +: 2];
              next_s.sample_rate =
                s.wdata[bmc_pkg::SAMPLE_RATE_BIT];
              next_s.unlock_cnt = 3'h0;
            end
          end
          bmc_pkg::IDX_WARN_LEVEL: begin
            next_s.warn_level = s.wdata[1:0];
          end
          bmc_pkg::IDX_WARN_IRQ_CTRL: begin
            next_s.trig_sel = s.wdata[bmc_pkg::TRIG_LSB +: 2];
            next_s.irq_en = s.wdata[bmc_pkg::IRQ_EN_BIT];
          end
          default: begin
            next_s.wdata = s.wdata; // Read-only, flag and clear registers handled above, or unmapped
          end
        endcase
      end
    end

    // Power phase tracking
    unique case (s.phase)
      bmc_pkg::PH_ACTIVE: begin
        if (deep_sleep) begin
          next_s.phase = bmc_pkg::PH_SLEEP;
        end
      end
      bmc_pkg::PH_SLEEP: begin
        if (!deep_sleep) begin
          if (s.active_mode == bmc_pkg::MODE_ENABLED_HOLD) begin
            next_s.phase = bmc_pkg::PH_WAKE_WAIT;
          end else begin
            next_s.phase = bmc_pkg::PH_ACTIVE;
          end
        end
      end
      bmc_pkg::PH_WAKE_WAIT: begin
        if (pins_q.detector_ready) begin
          next_s.phase = bmc_pkg::PH_ACTIVE;
        end
      end
      default: begin
        next_s.phase = bmc_pkg::PH_ACTIVE; // Illegal code
      end
    endcase

    // Slow tick counter for sampled mode
    next_s.lp_prev = pins_q.lp_clk;
    if (lp_tick) begin
      if (s.tick_cnt >= period - 9'h001) begin
        next_s.tick_cnt = 9'h000;
      end else begin
        next_s.tick_cnt = s.tick_cnt + 9'h001;
      end
    end

    // Comparator enable and detector mode outputs
    next_s.det_mode = eff_mode;
    if (eff_mode == bmc_pkg::MODE_SAMPLED) begin
      next_s.comp_en = (s.tick_cnt < bmc_pkg::WINDOW_TICKS);
    end else begin
      next_s.comp_en = det_on;
    end
    next_s.wake_hold = (next_s.phase == bmc_pkg::PH_WAKE_WAIT);

    // Reading of supply levels; flag set wins over a clear
    if (!det_on) begin
      next_s.below_held = 1'b0;
    end else if (sample_now) begin
      next_s.below_held = pins_q.below_threshold;
      next_s.warn_state = warn_new;
      if (trigger) begin
        next_s.irq_flag = 1'b1;
      end
    end

    // Synchronous reset loads the fuse
    if (!aresetn) begin
      next_s = '0;
      next_s.phase = bmc_pkg::PH_ACTIVE;
      next_s.sample_rate = detector_config_fuse.sample_rate;
      next_s.active_mode = detector_config_fuse.active_mode;
      next_s.sleep_mode = detector_config_fuse.sleep_mode;
      next_s.threshold = detector_config_fuse.threshold;
      next_s.warn_level = bmc_pkg::WARN_LEVEL_RESET;
      next_s.trig_sel = bmc_pkg::TRIG_RESET;
      next_s.irq_en = bmc_pkg::IRQ_EN_RESET;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge aclk) begin
    s <= next_s;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign s_axi_bvalid = s.bvalid;
  assign s_axi_bresp = s.bresp;
  assign s_axi_rvalid = s.rvalid;
  assign s_axi_rdata = s.rdata;
  assign s_axi_rresp = s.rresp;
  assign comparator_enable = s.comp_en;
  assign brownout_detector_mode = s.det_mode;
  assign threshold_select = s.threshold;
  assign warning_level_select = s.warn_level;
  assign wake_hold = s.wake_hold;
  assign reset_request = s.below_held;
  assign irq = s.irq_flag && s.irq_en;

endmodule : bmc_control

// ---- testbench/bmc_far_model.sv ----
`timescale 1ns/100ps
// Far side: slow clock and supply comparators
module bmc_far_model (
  input wire logic aclk,
  input wire logic supply_low,
  input wire logic warn_low,
  input wire logic det_ready,
  output bmc_pkg::bmc_pins_t pins
);
  logic [1:0] div = 2'h0; // Slow clock divider
  logic lp = 1'b0; // Slow clock, period of eight cycles

  ////////////////////////////////////////////////////////////////////////////
  // Slow clock toggles every fourth cycle
  always @(posedge aclk) begin
    div <= div + 2'h1;
    if (div == 2'h3) begin
      lp <= !lp;
    end
  end

  // Comparator levels and detector ready
  assign pins = {lp, supply_low, warn_low, det_ready};
endmodule : bmc_far_model

// ---- testbench/bmc_control_checker.sv ----
`timescale 1ns/100ps
// Watches the control block at its ports
module bmc_control_checker (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic deep_sleep,
  input wire logic comparator_enable,
  input wire logic [1:0] brownout_detector_mode,
  input wire logic [2:0] threshold_select,
  input wire logic [1:0] warning_level_select,
  input wire logic reset_request
);
  // One clock domain
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  ////////////////////////////////////////////////////////////////////////////
  // Bus handshakes
  write_answer_a: assert property (s_axi_awvalid && s_axi_awready &&
    s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write answer missing");
  write_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer lost");
  write_busy_a: assert property (s_axi_bvalid |->
    !s_axi_awready && !s_axi_wready) else $error("ready during answer");
  read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid && s_axi_rdata[31:8] == 24'h0)
    else $error("read answer wrong");
  read_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer lost");

  ////////////////////////////////////////////////////////////////////////////
  // Detector behaviour
  sleep_mode_a: assert property (
    deep_sleep [*3] |->
    brownout_detector_mode != bmc_pkg::MODE_ENABLED_HOLD)
    else $error("hold mode in sleep");
  comp_gate_a: assert property (
    comparator_enable |->
    brownout_detector_mode != bmc_pkg::MODE_DISABLED)
    else $error("comparator on while detector off");
  comp_on_a: assert property (
    brownout_detector_mode == bmc_pkg::MODE_ENABLED |-> comparator_enable)
    else $error("comparator off while enabled");
  off_clear_a: assert property (
    brownout_detector_mode == bmc_pkg::MODE_DISABLED [*3] |->
    !reset_request) else $error("reset request while off");
  level_write_a: assert property (
    $changed(warning_level_select) |->
    s_axi_bvalid || $past(s_axi_bvalid))
    else $error("warning level moved without write");
  level_fixed_a: assert property ($stable(threshold_select))
    else $error("threshold moved");
endmodule : bmc_control_checker

bind bmc_control bmc_control_checker bmc_control_checker_inst (
  .aclk(aclk),
  .aresetn(aresetn),
  .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata),
  .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready),
  .deep_sleep(deep_sleep),
  .comparator_enable(comparator_enable),
  .brownout_detector_mode(brownout_detector_mode),
  .threshold_select(threshold_select),
  .warning_level_select(warning_level_select),
  .reset_request(reset_request)
);

// ---- testbench/bmc_tb.sv ----
`timescale 1ns/100ps
// Register-level bench for the detector control block
module tb;
  localparam logic [1:0] OK = bmc_pkg::RESP_OKAY; // Mapped answer
  localparam logic [1:0] ER = bmc_pkg::RESP_SLVERR; // Unmapped answer
  bmc_pkg::bmc_fuse_t fuse = 8'h32; // Rate 0, on, sampled, 2
  logic [3:0] strb = 4'hF; // Write lanes
  logic aclk = 1'b0, aresetn = 1'b0; // Clock and reset
  logic [7:0] awaddr = 8'h00, araddr = 8'h00; // Bus addresses
  logic [31:0] wdata = 32'h0, rdata; // Bus data
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0; // Write side
  logic arvalid = 1'b0, rready = 1'b0; // Read side
  logic awready, wready, bvalid, arready, rvalid; // Slave answers
  logic [1:0] bresp, rresp, det_mode, wlvl; // Codes and modes
  logic deep_sleep = 1'b0, key = 1'b0, instr = 1'b0; // Sleep, guard
  logic supply_low = 1'b0, warn_low = 1'b0, det_ready = 1'b1; // Far side
  logic wake_hold, comp_en, rst_req, irq; // Status outputs
  logic [2:0] thr; // Threshold output
  bmc_pkg::bmc_pins_t pins; // Far-side pins
  int fail_count = 0, n_checks = 0, i, t, p; // Counters

  always #2.5 aclk = !aclk; // 200 MHz

  bmc_control bmc_control_inst (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(strb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .detector_config_fuse(fuse),
    .deep_sleep(deep_sleep), .wake_hold(wake_hold),
    .io_register_unlock_key(key), .instr_retired(instr),
    .analog_pins(pins), .comparator_enable(comp_en),
    .brownout_detector_mode(det_mode), .threshold_select(thr),
    .warning_level_select(wlvl), .reset_request(rst_req), .irq(irq));
  bmc_far_model bmc_far_model_inst (.aclk(aclk),
    .supply_low(supply_low), .warn_low(warn_low),
    .det_ready(det_ready), .pins(pins));

  ////////////////////////////////////////////////////////////////////////////
  // Verdict and end of run
  task automatic finish_test();
    if (fail_count == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : finish_test

  // Compare and count
  task automatic chk(input string n, input logic [31:0] e,
    input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      $display("unexpected %s exp %h got %h", n, e, g);
      fail_count++;
    end
  endtask : chk

  // Bound ran out
  task automatic hang();
    chk("wait", 32'h1, 32'h0);
    finish_test();
  endtask : hang

  // Bus write, both halves offered together
  task automatic wr(input logic [7:0] a, input logic [7:0] d,
    input logic [1:0] er);
    @(posedge aclk);
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge aclk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
      if (bvalid === 1'b1) break;
    end
    bready <= 1'b0;
    if (i == 50) hang();
    chk("bresp", {30'h0, er}, {30'h0, bresp});
  endtask : wr

  // Bus read with expected byte and answer
  task automatic rd(input logic [7:0] a, input logic [7:0] e,
    input logic [1:0] er);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge aclk);
      if (arready === 1'b1) arvalid <= 1'b0;
      if (rvalid === 1'b1) break;
    end
    rready <= 1'b0;
    if (i == 50) hang();
    chk("rdata", {24'h0, e}, rdata);
    chk("rresp", {30'h0, er}, {30'h0, rresp});
  endtask : rd

  // Key pulses or retired instructions
  task automatic pulse(input int n, input logic k);
    repeat (n) begin
      @(posedge aclk);
      key <= k;
      instr <= !k;
      @(posedge aclk);
      key <= 1'b0;
      instr <= 1'b0;
    end
  endtask : pulse

  // Wait for the comparator strobe level
  task automatic wait_comp(input logic v);
    for (i = 0; i < 1000; i++) begin
      @(posedge aclk);
      if (comp_en === v) break;
    end
    if (i == 1000) hang();
  endtask : wait_comp

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    rd(8'h00, 8'h06, OK);
    rd(8'h04, 8'h02, OK);
    chk("thr", 32'h2, {29'h0, thr});
    rd(8'h20, 8'h00, OK);
    rd(8'h24, 8'h00, OK);
    wr(8'h00, 8'h1D, OK);
    rd(8'h00, 8'h06, OK);
    pulse(1, 1'b1);
    wr(8'h00, 8'h1D, OK);
    rd(8'h00, 8'h15, OK);
    wr(8'h00, 8'h02, OK);
    rd(8'h00, 8'h15, OK);
    pulse(1, 1'b1);
    pulse(4, 1'b0);
    wr(8'h00, 8'h02, OK);
    rd(8'h00, 8'h15, OK);
    pulse(1, 1'b1);
    pulse(3, 1'b0);
    wr(8'h00, 8'h02, OK);
    rd(8'h00, 8'h06, OK);
    // Every sleep code, in and out of deep sleep
    for (t = 0; t < 4; t++) begin
      pulse(1, 1'b1);
      wr(8'h00, 8'(t), OK);
      deep_sleep <= 1'b1;
      repeat (4) @(posedge aclk);
      chk("mode", (t == 3) ? 0 : t, {30'h0, det_mode});
      if (t == 2) begin
        wait_comp(1'b0);
        wait_comp(1'b1);
        wait_comp(1'b0);
        p = i + 1;
        wait_comp(1'b1);
        chk("period", 32'(bmc_pkg::PERIOD_FAST) * 8, p + i + 1);
      end
      deep_sleep <= 1'b0;
      repeat (4) @(posedge aclk);
      chk("mode", 32'h1, {30'h0, det_mode});
    end
    wr(8'h04, 8'h07, OK);
    rd(8'h04, 8'h02, OK);
    wr(8'h20, 8'h02, OK);
    rd(8'h20, 8'h02, OK);
    chk("wlvl", 32'h2, {30'h0, wlvl});
    strb <= 4'hE;
    wr(8'h20, 8'h01, OK);
    strb <= 4'hF;
    rd(8'h20, 8'h02, OK);
    wr(8'h3C, 8'h01, ER);
    rd(8'h3C, 8'h00, ER);
    // Falling, rising and either trigger codes on a fall and a rise of the supply
    for (t = 0; t < 3; t++) begin
      wr(8'h24, 8'(t * 2 + 1), OK);
      warn_low <= 1'b1;
      repeat (8) @(posedge aclk);
      rd(8'h28, 8'(t != 1), OK);
      chk("irq", 32'(t != 1), {31'h0, irq});
      wr(8'h28, 8'h01, OK);
      warn_low <= 1'b0;
      repeat (8) @(posedge aclk);
      rd(8'h28, 8'(t != 0), OK);
      wr(8'h28, 8'h01, OK);
      chk("irq", 32'h0, {31'h0, irq});
    end
    // Masked flag, then the separate clear register
    wr(8'h24, 8'h04, OK);
    warn_low <= 1'b1;
    repeat (8) @(posedge aclk);
    rd(8'h28, 8'h01, OK);
    chk("irq", 32'h0, {31'h0, irq});
    wr(8'h30, 8'h01, OK);
    rd(8'h28, 8'h00, OK);
    rd(8'h30, 8'h00, OK);
    // Supply below threshold while enabled
    supply_low <= 1'b1;
    repeat (8) @(posedge aclk);
    chk("rst_req", 32'h1, {31'h0, rst_req});
    // Detector off in sleep drops the request
    deep_sleep <= 1'b1;
    repeat (4) @(posedge aclk);
    chk("rst_req", 32'h0, {31'h0, rst_req});
    // Second reset with hold mode and slow rate in the fuse
    supply_low <= 1'b0;
    deep_sleep <= 1'b0;
    fuse <= 8'hF2;
    aresetn <= 1'b0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    rd(8'h00, 8'h1E, OK);
    det_ready <= 1'b0;
    deep_sleep <= 1'b1;
    repeat (8) @(posedge aclk);
    chk("mode", 32'h2, {30'h0, det_mode});
    deep_sleep <= 1'b0;
    repeat (4) @(posedge aclk);
    chk("wake_hold", 32'h1, {31'h0, wake_hold});
    det_ready <= 1'b1;
    repeat (8) @(posedge aclk);
    chk("wake_hold", 32'h0, {31'h0, wake_hold});
    chk("mode", 32'h3, {30'h0, det_mode});
    finish_test();
  end
endmodule : tb
